// >>> rtl/ats_consts.vh
// Register map, field positions, reset values and encodings of the trigger sequencer
`ifndef ATS_CONSTS_VH
`define ATS_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define ATS_REG_CTRL      12'h000
`define ATS_REG_STATUS    12'h004
`define ATS_REG_RECLEN    12'h008
`define ATS_REG_REFPCT    12'h00c
`define ATS_REG_NUMREC    12'h010
`define ATS_REG_TRIGCFG   12'h014
`define ATS_REG_LEVEL     12'h018
`define ATS_REG_HYST      12'h01c
`define ATS_REG_HOLDOFF   12'h020
`define ATS_REG_DELAY     12'h024
`define ATS_REG_RECDONE   12'h028

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define ATS_CTRL_INIT     0
`define ATS_CTRL_ABORT    1
`define ATS_CTRL_RTONLY   2
`define ATS_CTRL_ETS      3
// TRIGCFG: [1:0] reference type, [2] slope, [4:3] start src, [6:5] advance src
`define ATS_TYPE_IMM      2'h0
`define ATS_TYPE_DIG      2'h1
`define ATS_TYPE_EDGE     2'h2
`define ATS_TYPE_HYST     2'h3
`define ATS_SRC_IMM       2'h0
`define ATS_SRC_DIG       2'h1
`define ATS_SLOPE_RISE    1'b0

// ------------------------------------------------------------
// Reset values and the percentage full scale
// ------------------------------------------------------------
`define ATS_RST_RECLEN    32'h0000_0400
`define ATS_RST_REFPCT    7'h32
`define ATS_RST_NUMREC    16'h0001
`define ATS_RST_TRIGCFG   7'h00
`define ATS_RST_RTONLY    1'b1
`define ATS_PCT_FULL      7'h64

`endif

// >>> rtl/ats_sequencer.v
// Acquisition trigger and record sequencer with APB registers and output buffer
// What this block does
// - After init, wait for the start trigger; start source defaults to immediate.
// - Start trigger begins collecting pre-trigger samples into the record.
// - Reference trigger is watched only once pre-trigger samples are complete.
// - On reference trigger, collect post-trigger samples, then close the record.
// - Records after the first start on the advance source, default immediate.
// - Acquire exactly the configured number of records, then report complete; a count of zero still acquires one record.
// - Reference position is a percentage of record length, default fifty.
// - Real-time-only flag, default true, forbids equivalent-time mode.
// - Digital reference triggering is refused in equivalent-time mode.
// - Edge triggers fire on rising or falling transition per slope, default rising.
// - Analog edge fires when comparator shows threshold crossed in chosen direction.
// - Hysteresis band on both sides of the threshold comes from the front-end band comparator pins, not from the HYST register.
// - Hysteresis fires after band edge passed, slope direction, then threshold crossed.
// - After a reference trigger, further reference triggers are ignored for holdoff cycles, default zero.
// - A reference trigger is acted on after the programmed delay, default zero.
// - Immediate triggering fires internally with no external condition.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "ats_consts.vh"

module ats_sequencer #(
  parameter DW = 16,
  parameter CW = 32
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Front end (asynchronous pins)
  input wire [DW-1:0] fe_sample,
  input wire fe_dig_trig,
  input wire fe_above_level,
  input wire fe_above_band,
  input wire fe_below_band,
  // Sample output stream
  output wire out_valid,
  input wire out_ready,
  output wire [DW-1:0] out_data,
  output wire out_last,
  output wire out_ref
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam S_IDLE = 5'h01;
  localparam S_WAIT_START = 5'h02;
  localparam S_PRE = 5'h04;
  localparam S_WAIT_REF = 5'h08;
  localparam S_POST = 5'h10;

  // ------------------------------------------------------------
  // Configuration and status registers
  // ------------------------------------------------------------
  reg [31:0] rec_len;
  reg [6:0] ref_pct;
  reg [15:0] num_rec;
  reg [6:0] trig_cfg;
  reg [31:0] level_cfg;
  reg [31:0] hyst_cfg;
  reg [CW-1:0] holdoff_cfg;
  reg [CW-1:0] delay_cfg;
  reg rt_only;
  reg ets_req;
  reg [4:0] state;
  reg [15:0] rec_done;
  reg acq_done;
  reg ref_refused;

  wire wr = psel & penable & pwrite;
  wire init_pulse = wr && paddr == `ATS_REG_CTRL && pwdata[`ATS_CTRL_INIT];
  wire abort_pulse = wr && paddr == `ATS_REG_CTRL && pwdata[`ATS_CTRL_ABORT];
  wire ets_mode = ets_req & ~rt_only;
  wire [1:0] ref_type = trig_cfg[1:0];
  wire slope = trig_cfg[2];
  wire [1:0] start_src = trig_cfg[4:3];
  wire [1:0] adv_src = trig_cfg[6:5];

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_len <= `ATS_RST_RECLEN;
      ref_pct <= `ATS_RST_REFPCT;
      num_rec <= `ATS_RST_NUMREC;
      trig_cfg <= `ATS_RST_TRIGCFG;
      level_cfg <= 32'h0000_0000;
      hyst_cfg <= 32'h0000_0000;
      holdoff_cfg <= {CW{1'b0}};
      delay_cfg <= {CW{1'b0}};
      rt_only <= `ATS_RST_RTONLY;
      ets_req <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `ATS_REG_CTRL: begin
          rt_only <= pwdata[`ATS_CTRL_RTONLY];
          ets_req <= pwdata[`ATS_CTRL_ETS];
        end
        `ATS_REG_RECLEN: rec_len <= pwdata;
        `ATS_REG_REFPCT: begin
          ref_pct <= (pwdata[6:0] > `ATS_PCT_FULL) ? `ATS_PCT_FULL : pwdata[6:0];
        end
        `ATS_REG_NUMREC: num_rec <= pwdata[15:0];
        `ATS_REG_TRIGCFG: trig_cfg <= pwdata[6:0];
        `ATS_REG_LEVEL: level_cfg <= pwdata;
        `ATS_REG_HYST: hyst_cfg <= pwdata;
        `ATS_REG_HOLDOFF: holdoff_cfg <= pwdata[CW-1:0];
        `ATS_REG_DELAY: delay_cfg <= pwdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `ATS_REG_CTRL: prdata = {28'h0, ets_req, rt_only, 2'b00};
      `ATS_REG_STATUS: prdata = {25'h0, ref_refused, acq_done, state};
      `ATS_REG_RECLEN: prdata = rec_len;
      `ATS_REG_REFPCT: prdata = {25'h0, ref_pct};
      `ATS_REG_NUMREC: prdata = {16'h0, num_rec};
      `ATS_REG_TRIGCFG: prdata = {25'h0, trig_cfg};
      `ATS_REG_LEVEL: prdata = level_cfg;
      `ATS_REG_HYST: prdata = hyst_cfg;
      `ATS_REG_HOLDOFF: prdata[CW-1:0] = holdoff_cfg;
      `ATS_REG_DELAY: prdata[CW-1:0] = delay_cfg;
      `ATS_REG_RECDONE: prdata = {16'h0, rec_done};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Sample word is assumed stable around the flag edges of the front end
  reg [DW+3:0] sync1;
  reg [DW+3:0] sync2;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= {(DW+4){1'b0}};
      sync2 <= {(DW+4){1'b0}};
    end else begin
      sync1 <= {fe_sample, fe_dig_trig, fe_above_level, fe_above_band, fe_below_band};
      sync2 <= sync1;
    end
  end
  wire [DW-1:0] smp = sync2[DW+3:4];
  wire dig_s = sync2[3];
  wire lvl_s = sync2[2];
  wire hi_s = sync2[1];
  wire lo_s = sync2[0];

  wire hyst_fire;
  reg dig_d;
  reg lvl_d;
  reg armed_h;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_d <= 1'b0;
      lvl_d <= 1'b0;
      armed_h <= 1'b0;
    end else begin
      dig_d <= dig_s;
      lvl_d <= lvl_s;
      if (state != S_WAIT_REF)
        armed_h <= 1'b0;
      else if (slope == `ATS_SLOPE_RISE ? lo_s : hi_s)
        armed_h <= 1'b1;
      else if (hyst_fire)
        armed_h <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Trigger detection
  // ------------------------------------------------------------
  function edge_sel;
    input cur;
    input prev;
    input slp;
    begin
      edge_sel = (slp == `ATS_SLOPE_RISE) ? (cur & ~prev) : (~cur & prev);
    end
  endfunction

  wire dig_edge = edge_sel(dig_s, dig_d, slope);
  wire lvl_edge = edge_sel(lvl_s, lvl_d, slope);
  assign hyst_fire = armed_h & lvl_edge;

  wire dig_refused = ets_mode && ref_type == `ATS_TYPE_DIG;
  reg raw_ref;
  always @* begin
    case (ref_type)
      `ATS_TYPE_IMM: raw_ref = 1'b1;
      `ATS_TYPE_DIG: raw_ref = dig_edge & ~dig_refused;
      `ATS_TYPE_EDGE: raw_ref = lvl_edge;
      `ATS_TYPE_HYST: raw_ref = hyst_fire;
      default: raw_ref = 1'b0;
    endcase
  end

  function src_fire;
    input [1:0] src;
    input dedge;
    begin
      src_fire = (src == `ATS_SRC_IMM) | ((src == `ATS_SRC_DIG) & dedge);
    end
  endfunction

  // ------------------------------------------------------------
  // Holdoff and delay
  // ------------------------------------------------------------
  reg [CW-1:0] hold_cnt;
  reg [CW-1:0] dly_cnt;
  reg dly_busy;
  wire ref_seen = (state == S_WAIT_REF) && !dly_busy && raw_ref && hold_cnt == {CW{1'b0}};
  wire ref_go = (ref_seen && delay_cfg == {CW{1'b0}}) ||
                (dly_busy && dly_cnt == {CW{1'b0}});

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  reg [31:0] pre_cnt;
  reg [31:0] post_cnt;
  reg [31:0] pre_need;
  reg [4:0] next_state;
  wire buf_ready;
  wire take = buf_ready;
  wire [38:0] pre_prod = rec_len * ref_pct;
  wire [38:0] pre_quot = pre_prod / `ATS_PCT_FULL;
  wire [31:0] pre_calc = pre_quot[31:0];

  wire start_ev = (rec_done == 16'h0000) ? src_fire(start_src, dig_edge)
                                         : src_fire(adv_src, dig_edge);

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: if (init_pulse) next_state = S_WAIT_START;
      S_WAIT_START: if (start_ev) next_state = S_PRE;
      S_PRE: if (take && pre_cnt + 32'h1 >= pre_need) next_state = S_WAIT_REF;
      S_WAIT_REF: if (ref_go) next_state = S_POST;
      S_POST: if (take && post_cnt <= 32'h1) next_state = S_WAIT_START;
      default: next_state = S_IDLE;
    endcase
    if (state == S_PRE && pre_need == 32'h0) next_state = S_WAIT_REF;
    if (state == S_POST && next_state == S_WAIT_START && rec_done + 16'h1 >= num_rec)
      next_state = S_IDLE;
    if (abort_pulse) next_state = S_IDLE;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      pre_cnt <= 32'h0;
      post_cnt <= 32'h0;
      pre_need <= 32'h0;
      rec_done <= 16'h0;
      acq_done <= 1'b0;
      ref_refused <= 1'b0;
      hold_cnt <= {CW{1'b0}};
      dly_cnt <= {CW{1'b0}};
      dly_busy <= 1'b0;
    end else begin
      state <= next_state;
      ref_refused <= dig_refused;
      if (init_pulse) begin
        rec_done <= 16'h0;
        acq_done <= 1'b0;
      end
      if (state == S_WAIT_START && next_state == S_PRE) begin
        pre_cnt <= 32'h0;
        pre_need <= pre_calc;
        post_cnt <= rec_len - pre_calc;
      end
      if (state == S_PRE && take) pre_cnt <= pre_cnt + 32'h1;
      if (state == S_POST && take) post_cnt <= post_cnt - 32'h1;
      if (state == S_POST && next_state != S_POST) begin
        rec_done <= rec_done + 16'h1;
        if (next_state == S_IDLE && !abort_pulse) acq_done <= 1'b1;
      end
      if (ref_seen)
        hold_cnt <= holdoff_cfg;
      else if (hold_cnt != {CW{1'b0}})
        hold_cnt <= hold_cnt - {{(CW-1){1'b0}}, 1'b1};
      if (ref_seen && delay_cfg != {CW{1'b0}}) begin
        dly_busy <= 1'b1;
        dly_cnt <= delay_cfg - {{(CW-1){1'b0}}, 1'b1};
      end else if (dly_busy) begin
        if (dly_cnt == {CW{1'b0}} || state != S_WAIT_REF)
          dly_busy <= 1'b0;
        else
          dly_cnt <= dly_cnt - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ------------------------------------------------------------
  // Two-entry output buffer
  // ------------------------------------------------------------
  // Pre-trigger samples stall rather than drop when the sink back-pressures
  wire capturing = (state == S_PRE && pre_need != 32'h0) || state == S_POST;
  wire in_last = state == S_POST && post_cnt <= 32'h1;
  wire in_ref = state == S_POST && post_cnt == rec_len - pre_need;
  reg [DW+1:0] mem [0:1];
  reg wp;
  reg rp;
  reg [1:0] cnt;
  wire push = capturing & buf_ready;
  wire pop = out_valid & out_ready;
  assign buf_ready = cnt != 2'h2;
  assign out_valid = cnt != 2'h0;
  assign out_data = mem[rp][DW+1:2];
  assign out_last = mem[rp][1];
  assign out_ref = mem[rp][0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem[0] <= {(DW+2){1'b0}};
      mem[1] <= {(DW+2){1'b0}};
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) begin
        mem[wp] <= {smp, in_last, in_ref};
        wp <= ~wp;
      end
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// >>> sim/ats_checker.sv
// Checker for stream order, record counts and status of the trigger sequencer
`timescale 1ns/1ps
`include "ats_consts.vh"
module ats_checker #(
  parameter DW = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  // Stream
  input wire out_valid,
  input wire out_ready,
  input wire [DW-1:0] out_data,
  input wire out_last,
  input wire out_ref
);
  wire wr = psel & penable & pwrite & pready;
  wire st = psel & (paddr == `ATS_REG_STATUS);
  wire pop = out_valid & out_ready;
  wire init_wr = wr & (paddr == `ATS_REG_CTRL) & pwdata[`ATS_CTRL_INIT];
  reg [31:0] len;
  reg [6:0] pct;
  reg [15:0] nrec;
  reg [15:0] recs;
  reg [31:0] pops;
  reg [6:0] cfg;
  reg rt;
  reg ets;
  wire [38:0] prod = len * pct;
  wire [38:0] pre = prod / 39'd100;
  // Shadow copies of the settings, taken from the bus writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len <= `ATS_RST_RECLEN;
      pct <= `ATS_RST_REFPCT;
      nrec <= `ATS_RST_NUMREC;
      cfg <= `ATS_RST_TRIGCFG;
      rt <= `ATS_RST_RTONLY;
      ets <= 1'b0;
      pops <= 32'h0;
      recs <= 16'h0;
    end else begin
      if (wr && paddr == `ATS_REG_RECLEN) len <= pwdata;
      if (wr && paddr == `ATS_REG_REFPCT)
        pct <= (pwdata[6:0] > `ATS_PCT_FULL) ? `ATS_PCT_FULL : pwdata[6:0];
      if (wr && paddr == `ATS_REG_NUMREC) nrec <= pwdata[15:0];
      if (wr && paddr == `ATS_REG_TRIGCFG) cfg <= pwdata[6:0];
      if (wr && paddr == `ATS_REG_CTRL) rt <= pwdata[`ATS_CTRL_RTONLY];
      if (wr && paddr == `ATS_REG_CTRL) ets <= pwdata[`ATS_CTRL_ETS];
      if (init_wr || (pop && out_last)) pops <= 32'h0;
      else if (pop) pops <= pops + 32'h1;
      if (init_wr) recs <= 16'h0;
      else if (pop && out_last) recs <= recs + 16'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pop_ref; pop && out_ref; endsequence
  sequence s_pop_last; pop && out_last; endsequence
  sequence s_stall; out_valid && !out_ready; endsequence
  sequence s_imm_init; init_wr && cfg[4:3] == `ATS_SRC_IMM && pre != 39'd0; endsequence
  AST_RESET_QUIET: assert property ($rose(presetn) |-> !out_valid)
    else $error("stream word right after reset");
  AST_STATE_ONEHOT: assert property (st |-> $onehot(prdata[4:0]))
    else $error("state field not one-hot");
  AST_IDLE_QUIET: assert property (st && prdata[0] && !out_valid |=> !out_valid)
    else $error("word captured while idle");
  AST_IMM_START: assert property (s_imm_init |-> ##[1:12] out_valid)
    else $error("no sample after immediate start");
  AST_HOLD: assert property (s_stall |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled word changed");
  AST_REF_POS: assert property (s_pop_ref |-> pops == pre[31:0])
    else $error("reference mark at wrong index");
  AST_LAST_POS: assert property (s_pop_last |-> pops == len - 32'h1)
    else $error("last mark at wrong index");
  AST_DONE_COUNT: assert property (st && prdata[5] && !out_valid |-> recs == nrec)
    else $error("done with wrong record count");
  AST_ETS_REFUSE: assert property (st |-> prdata[6] == (ets && !rt && cfg[1:0] == 2'h1))
    else $error("refusal flag wrong");
endmodule
bind ats_sequencer ats_checker #(.DW(DW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_last(out_last), .out_ref(out_ref));

// >>> sim/ats_fe_model.sv
// Front end model: running sample stream and threshold comparators
`timescale 1ns/1ps
module ats_fe_model #(
  parameter DW = 16,
  parameter integer LEVEL = 0,
  parameter integer HYST = 20
) (
  // Clock and analog level
  input wire pclk,
  input wire presetn,
  input wire signed [15:0] volts,
  // Pins
  output reg [DW-1:0] fe_sample,
  output wire fe_dig_trig,
  output wire fe_above_level,
  output wire fe_above_band,
  output wire fe_below_band
);
  // Changes each cycle so a stale sample cannot pass unseen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) fe_sample <= {DW{1'b0}};
    else fe_sample <= fe_sample + 1'b1;
  end
  assign fe_dig_trig = volts > LEVEL;
  assign fe_above_level = volts > LEVEL;
  assign fe_above_band = volts > LEVEL + HYST;
  assign fe_below_band = volts < LEVEL - HYST;
endmodule

// >>> sim/ats_sequencer_bench.sv
// Self-checking bench for the acquisition trigger sequencer
`timescale 1ns/1ps
`include "ats_consts.vh"
module ats_sequencer_bench;
  localparam [15:0] HI = 16'h0032, LO = 16'hffce, IH = 16'h0005, IL = 16'hfffb;
  reg pclk, presetn, psel, penable, pwrite, out_ready, rnd, have_d, serr;
  reg [15:0] last_d;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg signed [15:0] volts;
  wire [31:0] prdata;
  wire pready, pslverr, out_valid, out_last, out_ref, dig, al, ab, bb;
  wire [15:0] out_data, smp;
  integer err_count, checks, seed, cyc, lat, lat0;
  reg [1:0] expq[$];
  ats_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fe_sample(smp), .fe_dig_trig(dig), .fe_above_level(al),
    .fe_above_band(ab), .fe_below_band(bb), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last), .out_ref(out_ref));
  ats_fe_model fe (.pclk(pclk), .presetn(presetn), .volts(volts), .fe_sample(smp),
    .fe_dig_trig(dig), .fe_above_level(al), .fe_above_band(ab), .fe_below_band(bb));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input [31:0] e, input [31:0] g, input [8*8:1] what);
    checks = checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("mismatch %0s expected %h seen %h", what, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdchk(input [11:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rd, "register");
    chk(0, serr, "slverr");
  endtask
  task wait_st(input integer b);
    integer n;
    n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 400) begin
      apb(1'b0, `ATS_REG_STATUS, 32'h0);
      n = n + 1;
    end
    chk(1, rd[b], "wait");
  endtask
  task note(input integer n, input integer p, input integer r);
    integer i;
    integer j;
    for (j = 0; j < r; j = j + 1)
      for (i = 0; i < n; i = i + 1)
        expq.push_back({i == n - 1, i == n * p / 100});
  endtask
  task setup(input integer n, input integer p, input integer r);
    apb(1'b1, `ATS_REG_RECLEN, n);
    apb(1'b1, `ATS_REG_REFPCT, p);
    apb(1'b1, `ATS_REG_NUMREC, r);
    note(n, p, r);
  endtask
  task ref_run(input [6:0] cfg, input [31:0] dly, input [95:0] v);
    integer k;
    volts <= v[95:80];
    apb(1'b1, `ATS_REG_TRIGCFG, {25'h0, cfg});
    apb(1'b1, `ATS_REG_DELAY, dly);
    setup(8, 50, 1);
    apb(1'b1, `ATS_REG_CTRL, 32'h5);
    wait_st(3);
    for (k = 1; k < 5; k = k + 1) begin
      volts <= v[95-16*k -: 16];
      repeat (8) @(posedge pclk);
    end
    chk(0, out_valid, "quiet");
    volts <= v[15:0];
    lat = 0;
    while (out_valid !== 1'b1 && lat < 200) begin
      @(posedge pclk);
      lat = lat + 1;
    end
    chk(1, out_valid, "fired");
    wait_st(0);
    $display("test trigger cfg %h done", cfg);
  endtask
  always @(posedge pclk) begin
    out_ready <= rnd ? (($random(seed) & 1) != 0) : 1'b1;
    cyc <= cyc + 1;
    if (presetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (expq.size() == 0) chk(0, 1, "extra");
      else chk(expq.pop_front(), {out_last, out_ref}, "marks");
      // Without stalls each phase takes one front-end sample per cycle
      if (!rnd && have_d && !out_ref) chk({16'h0, last_d + 16'h1}, out_data, "data");
      last_d <= out_data;
      have_d <= !out_last;
    end
    if (cyc == 40000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  initial begin
    {psel, penable, pwrite, rnd, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    out_ready = 1'b1;
    have_d = 1'b0;
    volts = LO;
    {seed, err_count, checks, cyc} = {32'd97, 96'h0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`ATS_REG_STATUS, 32'h1);
    rdchk(`ATS_REG_RECLEN, `ATS_RST_RECLEN);
    rdchk(`ATS_REG_REFPCT, 32'd50);
    rdchk(`ATS_REG_NUMREC, 32'h1);
    rdchk(`ATS_REG_TRIGCFG, 32'h0);
    rdchk(12'hffc, 32'h0);
    apb(1'b0, `ATS_REG_CTRL, 32'h0);
    chk(1, rd[`ATS_CTRL_RTONLY], "realtime");
    $display("test defaults done");
    setup(10, 30, 3);
    rnd <= 1'b1;
    apb(1'b1, `ATS_REG_CTRL, 32'h5);
    wait_st(0);
    repeat (100) @(posedge pclk);
    rnd <= 1'b0;
    chk(0, expq.size(), "left");
    chk(1, rd[5], "done");
    rdchk(`ATS_REG_RECDONE, 32'h3);
    $display("test multi record done");
    ref_run(7'h01, 0, {LO, LO, LO, LO, LO, HI});
    lat0 = lat;
    ref_run(7'h01, 12, {LO, LO, LO, LO, LO, HI});
    chk(lat0 + 12, lat, "delay");
    ref_run(7'h05, 0, {LO, HI, HI, HI, HI, LO});
    ref_run(7'h02, 0, {HI, LO, LO, LO, LO, HI});
    ref_run(7'h03, 0, {HI, IH, IL, IH, LO, HI});
    apb(1'b1, `ATS_REG_TRIGCFG, 32'h0);
    apb(1'b1, `ATS_REG_HOLDOFF, 32'h12c);
    setup(4, 50, 2);
    apb(1'b1, `ATS_REG_CTRL, 32'h5);
    repeat (150) @(posedge pclk);
    rdchk(`ATS_REG_STATUS, 32'h8);
    wait_st(0);
    repeat (4) @(posedge pclk);
    chk(0, expq.size(), "left");
    apb(1'b1, `ATS_REG_HOLDOFF, 32'h0);
    $display("test holdoff done");
    apb(1'b1, `ATS_REG_TRIGCFG, 32'h1);
    apb(1'b1, `ATS_REG_CTRL, 32'h8);
    apb(1'b0, `ATS_REG_STATUS, 32'h0);
    chk(1, rd[6], "refused");
    apb(1'b1, `ATS_REG_CTRL, 32'hc);
    apb(1'b0, `ATS_REG_STATUS, 32'h0);
    chk(0, rd[6], "refused");
    $display("test equivalent time done");
    repeat (2) expq.push_back(2'b00);
    apb(1'b1, `ATS_REG_CTRL, 32'h5);
    wait_st(3);
    apb(1'b1, `ATS_REG_CTRL, 32'h6);
    rdchk(`ATS_REG_STATUS, 32'h1);
    chk(0, expq.size(), "left");
    $display("test abort done");
    end_sim;
  end
endmodule
